// ---- dv/acquisition_trigger_start_bench.sv ----
`timescale 1ns/100ps
module acquisition_trigger_start_bench;
    import trig_pkg::*;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0;
    logic [3:0]        s_axi_wstrb = 4'hF;
    logic              s_axi_awvalid = 1'b0;
    logic              s_axi_wvalid = 1'b0;
    logic              s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0;
    logic              s_axi_rready = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [31:0]       s_axi_rdata;
    logic              trig_in1, trig_in2, start_pulse;
    logic [NUM_CH-1:0] group_start, filter_en;
    logic [15:0]       irq = 16'h0000;
    int                fail_count = 0;
    int                checks = 0;
    int                pulses = 0;
    int                seed = 32'h537e;
    always #12.5 aclk = ~aclk;
    acquisition_trigger_start DUT (.*);
    trig_source src (.aclk, .trig_in1, .trig_in2);
    always @(posedge aclk) begin
        if (start_pulse === 1'b1) begin
            pulses++;
            chk(32'(group_start), 32'(irq));
        end
    end
    // ----------
    // Tasks
    // ----------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic give_up(input bit done);
        if (!done) begin
            fail_count++;
            print_verdict();
        end
    endtask : give_up
    // A late bready keeps the response stall path exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done = 0;
        int slow = $unsigned($random(seed)) % 3;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end else if (i >= slow) s_axi_bready <= 1'b1;
        end
        give_up(done);
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
        give_up(done);
        @(posedge aclk);
    endtask : rd
    function automatic bit fires(int mode, bit gate, bit lvl2, bit rise);
        return ((mode == 1 && rise) || (mode == 2 && !rise)) && (!gate || lvl2);
    endfunction : fires
    function automatic logic [15:0] fan(logic [3:0] f);
        return {{4{f[3]}}, {4{f[2]}}, {4{f[1]}}, {4{f[0]}}};
    endfunction : fan
    // ----------
    // Main sequence
    // ----------
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [3:0]  filt;
        bit          l2;
        bit          rise;
        int          base;
        int          total;
        total = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(CTRL_OFS, d, r);
        chk(d, ZERO_WORD);
        rd(8'h10, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        chk(d, ZERO_WORD);
        wr(8'h10, 32'hFFFF_FFFF, r);
        chk(32'(r), 32'(RESP_SLVERR));
        $display("register test done");
        for (int m = 0; m < 4; m++) begin
            irq = 16'($random(seed));
            wr(IRQGRP_OFS, 32'(irq), r);
            chk(32'(r), 32'(RESP_OKAY));
            for (int k = 0; k < 8; k++) begin
                filt = 4'($random(seed));
                l2 = 1'($random(seed));
                rise = !trig_in1;
                // Gate follows k[1] so every edge direction meets both gate settings
                wr(CTRL_OFS, {24'h0, filt, 1'b0, k[1], 2'(m)}, r);
                chk(32'(r), 32'(RESP_OKAY));
                chk(32'(filter_en), 32'(fan(filt)));
                src.drive(trig_in1, l2, 4);
                base = pulses;
                src.drive(rise, l2, 8);
                chk(32'(pulses - base), 32'(fires(m, k[1], l2, rise)));
                total += int'(fires(m, k[1], l2, rise));
                rd(STATUS_OFS, d, r);
                chk(32'(r), 32'(RESP_OKAY));
                chk(d, {30'h0, l2, rise});
            end
            $display("trigger mode %0d test done", m);
        end
        rd(COUNT_OFS, d, r);
        chk(d, 32'(total));
        wr(COUNT_OFS, ZERO_WORD, r);
        rd(COUNT_OFS, d, r);
        chk(d, ZERO_WORD);
        $display("count test done");
        print_verdict();
    end
endmodule : acquisition_trigger_start_bench

// ---- dv/trig_source.sv ----
`timescale 1ns/100ps
module trig_source (
    input wire logic aclk,
    output logic     trig_in1,
    output logic     trig_in2
);
    initial begin
        trig_in1 = 1'b0;
        trig_in2 = 1'b0;
    end
    // Levels change just after an edge and stay for hold cycles
    task automatic drive(input logic l1, input logic l2, input int hold);
        @(posedge aclk);
        trig_in1 <= l1;
        trig_in2 <= l2;
        repeat (hold) @(posedge aclk);
    endtask : drive
endmodule : trig_source

// ---- dv/trig_start_sva.sv ----
`timescale 1ns/100ps
module trig_start_sva
    import trig_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              trig_in1,
    input wire logic              start_pulse,
    input wire logic [NUM_CH-1:0] group_start,
    input wire logic [NUM_CH-1:0] filter_en,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------
    // Bus steps
    // ----------
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_one_pulse: assert property (start_pulse |=> !start_pulse)
        else $error("start pulse too long");
    a_group_idle: assert property (!start_pulse |-> group_start == '0)
        else $error("group start without pulse");
    // Two sync stages plus the start flop put the causing edge exactly here
    a_pulse_cause: assert property (start_pulse |->
        $past(trig_in1, 3) != $past(trig_in1, 4))
        else $error("start pulse without input edge");
    a_filter_block: assert property (filter_en == {{4{filter_en[12]}},
        {4{filter_en[8]}}, {4{filter_en[4]}}, {4{filter_en[0]}}})
        else $error("filter block split");
    a_write_resp: assert property (aw_w_taken |=> s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_read_resp: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read response late");
endmodule : trig_start_sva
bind acquisition_trigger_start trig_start_sva sva (.*);

// ---- inc/trig_pkg.sv ----
package trig_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] IRQGRP_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS  = 8'h0C;
    localparam int         ADDR_W     = 8;

    // ------------------------------------------------------------
    // Field layout of the control register
    // ------------------------------------------------------------
    localparam int MODE_LSB   = 0;
    localparam int MODE_W     = 2;
    localparam int GATE_BIT   = 2;
    localparam int FILT_LSB   = 4;
    localparam int NUM_BLOCKS = 4;
    localparam int NUM_CH     = 16;
    localparam int CH_PER_BLK = 4;

    // ------------------------------------------------------------
    // Status layout
    // ------------------------------------------------------------
    localparam int ST_T1_BIT = 0;
    localparam int ST_T2_BIT = 1;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
    localparam logic [15:0] IRQGRP_RST  = 16'h0000;
    localparam logic [3:0]  FILT_RST    = 4'h0;

    typedef enum logic [1:0] {
        MODE_OFF     = 2'b00,
        MODE_RISING  = 2'b01,
        MODE_FALLING = 2'b10
    } trig_mode_e;

endpackage : trig_pkg

// ---- rtl/acquisition_trigger_start.sv ----
`timescale 1ns/100ps
module acquisition_trigger_start
    import trig_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  trig_in1,
    input  wire logic                  trig_in2,
    output logic                       start_pulse,
    output logic [NUM_CH-1:0]          group_start,
    output logic [NUM_CH-1:0]          filter_en,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [MODE_W-1:0]     mode_reg;
    logic                  gate_reg;
    logic [NUM_BLOCKS-1:0] filt_reg;
    logic [NUM_CH-1:0]     irqgrp_reg;
    logic [31:0]           count_reg;
    logic                  start_reg;
    logic [NUM_CH-1:0]     group_reg;

    // ------------------------------------------------------------
    // Trigger input conditioning
    // ------------------------------------------------------------
    logic t1_level;
    logic t1_rise;
    logic t1_fall;
    logic t2_level;

    edge_sync u_sync1 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (trig_in1),
        .level   (t1_level),
        .rise    (t1_rise),
        .fall    (t1_fall)
    );

    edge_sync u_sync2 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (trig_in2),
        .level   (t2_level),
        .rise    (),
        .fall    ()
    );

    // ------------------------------------------------------------
    // Qualification
    // ------------------------------------------------------------
    wire mode_rise  = (mode_reg == MODE_RISING);
    wire mode_fall  = (mode_reg == MODE_FALLING);
    // Off and the unused code select no edge at all
    wire sel_edge   = (mode_rise & t1_rise) | (mode_fall & t1_fall);
    // Gate samples input two in the same cycle as the edge
    wire gate_ok    = ~gate_reg | t2_level;
    wire start_next = sel_edge & gate_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_reg <= 1'b0;
            group_reg <= IRQGRP_RST;
        end else begin
            start_reg <= start_next;
            group_reg <= start_next ? irqgrp_reg : IRQGRP_RST;
        end
    end

    assign start_pulse = start_reg;
    assign group_start = group_reg;

    // Each channel takes the setting of its block of four
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_filt
            assign filter_en[gi] = filt_reg[gi / CH_PER_BLK];
        end
    endgenerate

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;

    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire  = s_axi_wvalid & s_axi_wready;
    wire have_aw = aw_held_reg | aw_fire;
    wire have_w  = w_held_reg | w_fire;
    wire do_wr   = have_aw & have_w;
    wire [ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0]       wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0]        wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire wr_ctrl   = do_wr & (wr_addr == CTRL_OFS);
    wire wr_irqgrp = do_wr & (wr_addr == IRQGRP_OFS);
    wire wr_count  = do_wr & (wr_addr == COUNT_OFS);
    wire wr_ok     = (wr_addr == CTRL_OFS) | (wr_addr == IRQGRP_OFS)
                   | (wr_addr == COUNT_OFS) | (wr_addr == STATUS_OFS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= ZERO_WORD;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (aw_fire) awaddr_reg <= s_axi_awaddr;
            if (w_fire) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            aw_held_reg <= have_aw & ~do_wr;
            w_held_reg  <= have_w & ~do_wr;
            if (do_wr) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // Settings only change on byte lanes software actually writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg   <= MODE_OFF;
            gate_reg   <= 1'b0;
            filt_reg   <= FILT_RST;
            irqgrp_reg <= IRQGRP_RST;
        end else begin
            if (wr_ctrl && wr_strb[0]) begin
                mode_reg <= wr_data[MODE_LSB +: MODE_W];
                gate_reg <= wr_data[GATE_BIT];
                filt_reg <= wr_data[FILT_LSB +: NUM_BLOCKS];
            end
            if (wr_irqgrp && wr_strb[0]) irqgrp_reg[7:0]  <= wr_data[7:0];
            if (wr_irqgrp && wr_strb[1]) irqgrp_reg[15:8] <= wr_data[15:8];
        end
    end

    // Any write to the counter clears it; a same-cycle start still counts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= ZERO_WORD;
        end else if (start_reg) begin
            count_reg <= wr_count ? 32'h0000_0001 : count_reg + 32'h0000_0001;
        end else if (wr_count) begin
            count_reg <= ZERO_WORD;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    assign s_axi_arready = ~rvalid_reg;
    wire ar_fire = s_axi_arvalid & s_axi_arready;
    wire [31:0] ctrl_word = {24'h000000, filt_reg, 1'b0, gate_reg, mode_reg};
    wire [31:0] stat_word = {30'h00000000, t2_level, t1_level};
    wire rd_ok = (s_axi_araddr == CTRL_OFS) | (s_axi_araddr == IRQGRP_OFS)
               | (s_axi_araddr == STATUS_OFS) | (s_axi_araddr == COUNT_OFS);
    wire [31:0] rd_mux = (s_axi_araddr == CTRL_OFS)   ? ctrl_word :
                         (s_axi_araddr == IRQGRP_OFS) ? {16'h0000, irqgrp_reg} :
                         (s_axi_araddr == STATUS_OFS) ? stat_word :
                         (s_axi_araddr == COUNT_OFS)  ? count_reg : ZERO_WORD;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= ZERO_WORD;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;
endmodule : acquisition_trigger_start

// ---- rtl/edge_sync.sv ----
`timescale 1ns/100ps
module edge_sync
    import trig_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    // ------------------------------------------------------------
    // Two-stage synchroniser plus one history stage
    // ------------------------------------------------------------
    logic meta_reg;
    logic sync_reg;
    logic hist_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            hist_reg <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            hist_reg <= sync_reg;
        end
    end

    // Edges compare consecutive synchronised samples only
    assign level = sync_reg;
    assign rise  = sync_reg & ~hist_reg;
    assign fall  = ~sync_reg & hist_reg;
endmodule : edge_sync
